// ---- src/serial_eeprom_bus_slave.sv ----
// Two-wire bus slave front end with page buffer and program-word stream.
// Assumes SCL and SDA pads resolve the wired-AND level and feed it back on scl_in/sda_in.
`timescale 1ns/10ps

module prog_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [PW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count_reg != (PW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module serial_eeprom_bus_slave #(
  parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES,
  parameter int POWERUP_CYCLES = eeprom_slave_pkg::POWERUP_CYCLES,
  parameter int FIFO_DEPTH = eeprom_slave_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic write_guard,
  input wire logic fast_plus_mode,
  output logic [13:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic prog_valid,
  input wire logic prog_ready,
  output eeprom_slave_pkg::prog_word_t prog_word,
  output logic busy
);
  logic [6:0] pin_s1_reg, pin_s2_reg;
  logic [1:0] filt;
  logic scl_p_reg, sda_p_reg;
  eeprom_slave_pkg::bus_state_t state_reg;
  eeprom_slave_pkg::byte_kind_t kind_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic rw_reg, guard_reg, first_reg, sda_oe_reg;
  logic [13:0] addr_reg;
  logic [7:0] page_buf [eeprom_slave_pkg::PAGE_BYTES];
  logic [63:0] mask_reg;
  logic busy_reg, ready_reg;
  logic [31:0] prog_cnt_reg, pu_cnt_reg;
  logic [6:0] drain_idx_reg;
  logic [7:0] page_lat_reg;
  logic fifo_in_ready;

  // Both bus lines and all straps cross into ref_clk through two flops.
  wire [6:0] pins = {fast_plus_mode, write_guard, chip_select_strap_2,
                     chip_select_strap_1, chip_select_strap_0, sda_in, scl_in};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg <= eeprom_slave_pkg::PIN_SYNC_RESET;
      pin_s2_reg <= eeprom_slave_pkg::PIN_SYNC_RESET;
    end else begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // A level must differ for the whole window before it is taken, so shorter
  // pulses vanish; the window costs that many cycles of latency.
  wire [2:0] filt_len = pin_s2_reg[6] ? eeprom_slave_pkg::FILTER_FP_CYCLES
                                      : eeprom_slave_pkg::FILTER_STD_CYCLES;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : line_filter
      logic level_reg;
      logic [2:0] cnt_reg;
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          level_reg <= 1'b1;
          cnt_reg <= '0;
        end else if (pin_s2_reg[g] == level_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == filt_len - 3'h1) begin
          level_reg <= pin_s2_reg[g];
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
      assign filt[g] = level_reg;
    end
  endgenerate

  wire scl_f = filt[0];
  wire sda_f = filt[1];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_p_reg <= scl_f;
      sda_p_reg <= sda_f;
    end
  end

  // An SDA rise while SCL stays high is a stop, and a fall is a start once ready_reg is set; never data.
  wire start_ev = scl_f && scl_p_reg && sda_p_reg && !sda_f && ready_reg;
  wire stop_ev = scl_f && scl_p_reg && !sda_p_reg && sda_f;
  wire rise_ev = scl_f && !scl_p_reg;
  wire fall_ev = !scl_f && scl_p_reg;

  wire [2:0] straps = pin_s2_reg[4:2];
  // Straps are pulled low at the pads, so open pins match address zero.
  wire addr_match = shift_reg[7:4] == eeprom_slave_pkg::SLAVE_FAMILY &&
                    shift_reg[3:1] == straps;
  wire byte_done = state_reg == eeprom_slave_pkg::S_RX && fall_ev &&
                   bit_cnt_reg == eeprom_slave_pkg::BITS_PER_BYTE;
  wire is_slave = kind_reg == eeprom_slave_pkg::KIND_SLAVE;
  wire is_data = kind_reg == eeprom_slave_pkg::KIND_DATA;
  // Address polling sees no acknowledge until programming ends.
  wire ack_ok = is_slave ? (addr_match && !busy_reg) :
                is_data ? (!guard_reg && !rw_reg) : 1'b1;
  wire buf_wr = byte_done && is_data && ack_ok;
  wire launch = stop_ev && (|mask_reg) && !busy_reg;
  wire [5:0] drain_idx = drain_idx_reg[5:0];
  wire drain_done = drain_idx_reg[6];
  wire drain_push = busy_reg && !drain_done && mask_reg[drain_idx] && fifo_in_ready;
  wire prog_over = prog_cnt_reg >= 32'(PROG_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= eeprom_slave_pkg::S_IDLE;
      kind_reg <= eeprom_slave_pkg::KIND_SLAVE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      rw_reg <= 1'b0;
      guard_reg <= 1'b0;
      first_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      addr_reg <= '0;
    end else if (stop_ev) begin
      state_reg <= eeprom_slave_pkg::S_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_ev && !busy_reg) begin
      state_reg <= eeprom_slave_pkg::S_RX;
      kind_reg <= eeprom_slave_pkg::KIND_SLAVE;
      bit_cnt_reg <= '0;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        eeprom_slave_pkg::S_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        eeprom_slave_pkg::S_RX: begin
          if (rise_ev) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done && !ack_ok) begin
            state_reg <= eeprom_slave_pkg::S_IDLE;
          end else if (byte_done) begin
            sda_oe_reg <= 1'b1;
            state_reg <= eeprom_slave_pkg::S_ACK;
            unique case (kind_reg)
              eeprom_slave_pkg::KIND_SLAVE: begin
                rw_reg <= shift_reg[0];
                kind_reg <= eeprom_slave_pkg::KIND_ADDR_HI;
              end
              eeprom_slave_pkg::KIND_ADDR_HI: begin
                addr_reg[13:8] <= shift_reg[5:0];
                kind_reg <= eeprom_slave_pkg::KIND_ADDR_LO;
              end
              eeprom_slave_pkg::KIND_ADDR_LO: begin
                addr_reg[7:0] <= shift_reg;
                kind_reg <= eeprom_slave_pkg::KIND_DATA;
                first_reg <= 1'b1;
              end
              eeprom_slave_pkg::KIND_DATA: begin
                addr_reg[5:0] <= addr_reg[5:0] + 6'h1;
              end
            endcase
          end
        end
        eeprom_slave_pkg::S_ACK: begin
          if (fall_ev) begin
            bit_cnt_reg <= '0;
            if (first_reg) begin
              guard_reg <= pin_s2_reg[5];
              first_reg <= 1'b0;
            end
            if (rw_reg) begin
              tx_reg <= mem_rd_data;
              sda_oe_reg <= !mem_rd_data[7];
              state_reg <= eeprom_slave_pkg::S_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= eeprom_slave_pkg::S_RX;
            end
          end
        end
        eeprom_slave_pkg::S_TX: begin
          if (rise_ev) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (fall_ev && bit_cnt_reg == eeprom_slave_pkg::BITS_PER_BYTE) begin
            sda_oe_reg <= 1'b0;
            state_reg <= eeprom_slave_pkg::S_TXACK;
          end else if (fall_ev) begin
            sda_oe_reg <= !tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        eeprom_slave_pkg::S_TXACK: begin
          if (rise_ev) begin
            addr_reg <= addr_reg + 14'h1;
            // A released line is a no-ack: the master is done with this read.
            state_reg <= sda_f ? eeprom_slave_pkg::S_IDLE : eeprom_slave_pkg::S_ACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (buf_wr) begin
      page_buf[addr_reg[5:0]] <= shift_reg;
    end
  end

  // The mask marks bytes of the current sequence only; any start taken while not busy wipes it,
  // so an abandoned sequence never reaches the array.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= '0;
    end else if (start_ev && !busy_reg) begin
      mask_reg <= '0;
    end else if (buf_wr) begin
      mask_reg[addr_reg[5:0]] <= 1'b1;
    end else if (drain_push) begin
      mask_reg[drain_idx] <= 1'b0;
    end
  end

  // Busy lasts the program time, stretched only if the sink stalls the drain.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      drain_idx_reg <= '0;
      page_lat_reg <= '0;
    end else if (launch) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= '0;
      drain_idx_reg <= '0;
      page_lat_reg <= addr_reg[13:6];
    end else if (busy_reg) begin
      if (!prog_over) begin
        prog_cnt_reg <= prog_cnt_reg + 32'h1;
      end
      if (!drain_done && (!mask_reg[drain_idx] || fifo_in_ready)) begin
        drain_idx_reg <= drain_idx_reg + 7'h1;
      end
      if (prog_over && drain_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (pu_cnt_reg >= 32'(POWERUP_CYCLES - 1)) begin
      ready_reg <= 1'b1;
    end else begin
      pu_cnt_reg <= pu_cnt_reg + 32'h1;
    end
  end

  eeprom_slave_pkg::prog_word_t push_word;
  assign push_word = '{addr: {page_lat_reg, drain_idx}, data: page_buf[drain_idx]};

  prog_fifo #(
    .WIDTH($bits(eeprom_slave_pkg::prog_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(busy_reg && !drain_done && mask_reg[drain_idx]),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_word)
  );

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign mem_rd_addr = addr_reg;
  assign busy = busy_reg;

  AST_IDLE_NEEDS_START: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_reg == eeprom_slave_pkg::S_IDLE && !start_ev |=> state_reg == eeprom_slave_pkg::S_IDLE)
    else $error("left idle without a start");
  AST_STOP_ENDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stop_ev |=> state_reg == eeprom_slave_pkg::S_IDLE && !sda_oe_reg)
    else $error("stop did not end the transfer");
  AST_DRIVE_ON_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(sda_oe_reg) |-> !scl_f)
    else $error("sda driven while scl high");
  AST_MATCH_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_done && is_slave && !(addr_match && !busy_reg) |=> !sda_oe_reg)
    else $error("foreign address acknowledged");
  AST_ACK_NINTH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_done && ack_ok |=> sda_oe_reg && state_reg == eeprom_slave_pkg::S_ACK)
    else $error("no acknowledge on ninth clock");
  AST_BUSY_SILENT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy_reg && state_reg == eeprom_slave_pkg::S_IDLE |=> !sda_oe_reg)
    else $error("sda driven during program cycle");
  AST_GUARD_NACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_done && is_data && guard_reg |=> !sda_oe_reg ##0 mask_reg == $past(mask_reg))
    else $error("guarded write accepted");
  AST_PAGE_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    buf_wr |=> addr_reg[13:6] == $past(addr_reg[13:6]) &&
      addr_reg[5:0] == $past(addr_reg[5:0]) + 6'h1)
    else $error("page index did not wrap in page");
  AST_LAUNCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    launch |=> busy_reg [*8])
    else $error("program cycle not held");
  AST_NOT_READY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ready_reg |-> state_reg == eeprom_slave_pkg::S_IDLE)
    else $error("command taken before power-up delay");

  COV_DATA_WRITE: cover property (@(posedge ref_clk) disable iff (!reset_n) buf_wr);
  COV_PROGRAM: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(busy_reg));
  COV_READ_BYTE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state_reg == eeprom_slave_pkg::S_TXACK && rise_ev && !sda_f);
endmodule

// ---- src/eeprom_slave_pkg.sv ----
// Constants, codes and carrier types for the two-wire memory slave front end.
// Assumes a 25 MHz ref_clk and that the bus pins are sampled, never used as clocks.
package eeprom_slave_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int GLITCH_STD_NS = 100;
  localparam int GLITCH_FP_NS = 50;
  localparam logic [2:0] FILTER_STD_CYCLES =
    3'((GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] FILTER_FP_CYCLES =
    3'((GLITCH_FP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWERUP_MS = 1;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] SLAVE_FAMILY = 4'ha;
  localparam int PAGE_BYTES = 64;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] PIN_SYNC_RESET = 7'h03;

  typedef enum logic [1:0] {
    KIND_SLAVE = 2'h0,
    KIND_ADDR_HI = 2'h1,
    KIND_ADDR_LO = 2'h2,
    KIND_DATA = 2'h3
  } byte_kind_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX = 5'h02,
    S_ACK = 5'h04,
    S_TX = 5'h08,
    S_TXACK = 5'h10
  } bus_state_t;

  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] data;
  } prog_word_t;

endpackage

// ---- test/bus_master_model.sv ----
// Bus master model for the two-wire memory slave: drives SCL and an open-drain SDA.
// Assumes the bench resolves the wired-AND SDA level and feeds it back on sda_line.
`timescale 1ns/10ps

module bus_master_model #(
  parameter int LOW_NS = 320,
  parameter int HIGH_NS = 160
) (
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  // SCL stands high between frames and SDA is released to its pull-up.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // The low phase is long because the slave sees SCL only after its input filter.
  task automatic bit_cycle(input logic b, output logic s);
    #(LOW_NS / 2) sda_rel = b;
    #(LOW_NS / 2) scl = 1'b1;
    #(HIGH_NS / 2) s = sda_line;
    #(HIGH_NS / 2) scl = 1'b0;
  endtask

  // The odd offset keeps bus edges out of step with the slave's clock.
  task automatic start();
    #13;
    if (scl === 1'b0) begin
      #(LOW_NS / 2) sda_rel = 1'b1;
      #(LOW_NS / 2) scl = 1'b1;
      #(HIGH_NS);
    end
    sda_rel = 1'b0;
    #(HIGH_NS) scl = 1'b0;
  endtask

  // Ends with the bus free time, so the next start finds an idle bus.
  task automatic stop();
    #(LOW_NS / 2) sda_rel = 1'b0;
    #(LOW_NS / 2) scl = 1'b1;
    #(HIGH_NS) sda_rel = 1'b1;
    #(LOW_NS);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(v[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // The caller withholds the last acknowledge and then issues the stop.
  task automatic recv_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      v[i] = s;
    end
    bit_cycle(~ack, s);
  endtask
endmodule

// ---- test/serial_eeprom_bus_slave_tb_top.sv ----
// Self-checking bench for the two-wire memory slave front end.
// Assumes the package, the design and the bus master model are compiled first.
`timescale 1ns/10ps

module serial_eeprom_bus_slave_tb_top;
  logic ref_clk, reset_n, scl, sda_rel, sda_out, sda_oe, write_guard, fast_plus_mode;
  logic prog_valid, prog_ready, busy, stall;
  logic [2:0] strap;
  logic [13:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic [7:0] pg [64];
  logic [63:0] vld;
  eeprom_slave_pkg::prog_word_t prog_word;
  eeprom_slave_pkg::prog_word_t exp_q [$];
  int mismatches, n_checks, seed;
  wire sda_line;

  // The device can only pull the line low; released, it reads high.
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

  serial_eeprom_bus_slave #(.PROG_CYCLES(200), .POWERUP_CYCLES(20),
    .FIFO_DEPTH(eeprom_slave_pkg::FIFO_DEPTH)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_0(strap[0]),
    .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
    .write_guard(write_guard), .fast_plus_mode(fast_plus_mode),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_word(prog_word), .busy(busy));

  bus_master_model bm (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

  function automatic logic [7:0] rd_pat(input logic [13:0] ad);
    return ad[7:0] ^ {ad[13:8], 2'h3};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // The sink stalls at random, and wholly while stall is set, so the FIFO fills.
  always @(posedge ref_clk) begin
    mem_rd_data <= rd_pat(mem_rd_addr);
    prog_ready <= !stall && (($random(seed) & 1) != 0);
  end

  always @(posedge ref_clk) begin
    if (reset_n === 1'b1 && prog_valid === 1'b1 && prog_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'(prog_word), 32'hffffffff, "stray word");
      end else begin
        check(32'(prog_word), 32'(exp_q.pop_front()), "word");
      end
    end
  end

  task automatic finish_write();
    logic a;
    realtime t0;
    int c;
    t0 = $realtime;
    @(negedge ref_clk);
    check(busy, 1, "busy");
    bm.start();
    bm.send_byte({eeprom_slave_pkg::SLAVE_FAMILY, strap, 1'b1}, a);
    check(a, 0, "poll ack");
    bm.stop();
    @(negedge ref_clk);
    if (stall) begin
      check(prog_valid, 1, "held word");
      stall = 1'b0;
    end
    c = 0;
    while ((busy !== 1'b0 || exp_q.size() > 0) && c < 9999) begin
      @(posedge ref_clk);
      c++;
    end
    @(negedge ref_clk);
    check(busy, 0, "busy stuck");
    check(exp_q.size(), 0, "words left");
    check(($realtime - t0) >= 7680.0, 1, "short cycle");
  endtask

  task automatic do_write(input logic [7:0] page, input logic [5:0] idx, input int n,
                          input logic rstart);
    logic a, g;
    logic [7:0] d;
    g = write_guard;
    vld = '0;
    bm.start();
    bm.send_byte({eeprom_slave_pkg::SLAVE_FAMILY, strap, 1'b0}, a);
    check(a, 1, "slave ack");
    bm.send_byte({2'h3, page[7:2]}, a);
    check(a, 1, "addr hi ack");
    bm.send_byte({page[1:0], idx}, a);
    check(a, 1, "addr lo ack");
    repeat (n) begin
      d = 8'($random(seed));
      bm.send_byte(d, a);
      check(a, !g, "data ack");
      pg[idx] = d;
      vld[idx] = !g;
      idx++;
    end
    for (int k = 0; k < 64; k++) begin
      if (vld[k] && !rstart) exp_q.push_back({page, 6'(k), pg[k]});
    end
    if (!rstart) begin
      bm.stop();
      if (g) begin
        @(negedge ref_clk);
        check(busy, 0, "guarded busy");
      end else begin
        finish_write();
      end
    end
  endtask

  initial begin
    logic a;
    logic [7:0] d;
    logic [13:0] ad;
    reset_n = 1'b0;
    {write_guard, fast_plus_mode, stall, prog_ready} = 4'h0;
    mem_rd_data = 8'h00;
    strap = 3'h0;
    mismatches = 0;
    n_checks = 0;
    seed = 73;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    strap <= 3'($random(seed));
    bm.start();
    bm.send_byte({eeprom_slave_pkg::SLAVE_FAMILY, strap, 1'b0}, a);
    check(a, 0, "early ack");
    bm.stop();
    for (int j = 0; j < 9; j++) begin
      d = (j == 8) ? {4'hb, strap, 1'b0} : {eeprom_slave_pkg::SLAVE_FAMILY, 3'(j), 1'b0};
      bm.start();
      bm.send_byte(d, a);
      check(a, (j < 8) && (3'(j) == strap), "address match");
      bm.stop();
    end
    stall = 1'b1;
    do_write(8'h5a, 6'h3e, 66, 1'b0);
    do_write(8'h11, 6'h05, 2, 1'b1);
    do_write(8'h11, 6'h07, 1, 1'b0);
    @(posedge ref_clk);
    write_guard <= 1'b1;
    @(posedge ref_clk);
    do_write(8'h22, 6'h00, 1, 1'b0);
    @(posedge ref_clk);
    write_guard <= 1'b0;
    fast_plus_mode <= 1'b1;
    ad = 14'h3ffe;
    bm.start();
    bm.send_byte({eeprom_slave_pkg::SLAVE_FAMILY, strap, 1'b0}, a);
    bm.send_byte({2'h0, ad[13:8]}, a);
    bm.send_byte(ad[7:0], a);
    bm.start();
    bm.send_byte({eeprom_slave_pkg::SLAVE_FAMILY, strap, 1'b1}, a);
    check(a, 1, "read ack");
    for (int k = 0; k < 3; k++) begin
      bm.recv_byte(k < 2, d);
      check(d, rd_pat(ad + 14'(k)), "read byte");
    end
    bm.stop();
    wrap_up();
  end

  initial begin
    #3000000;
    mismatches++;
    wrap_up();
  end
endmodule
